//--- logic/tim_mask_logic.sv
// Behaviour
// - Mask bit one enables, zero blocks event
// - Word0 bit7: terminal frame sync change interrupts
// - Word0 bit6: multiframe sync change interrupts
// - Word0 bit4: all-ones alarm start/end interrupts
// - Word0 bit3: signal loss change, vector 01000000
// - Word0 bit2: severely errored frame interrupts
// - Word0 bit1: transmit buffer slip interrupts
// - Word0 bit0: receive buffer slip interrupts
// - Word1 bit7: framing bit error, only in sync
// - Word1 bit6: local CRC-6 error interrupts
// - Word1 bit5: received yellow alarm interrupts
// - Word1 bit4: alignment change after reframe
// - Word1 bit3: bipolar violation, B8ZS excluded
// - Word1 bit2: PRBS channel error interrupts
// - Word1 bit1: pulse density violation interrupts
// - Word2 bit7: framing error counter wrap
// - Word2 bit6: CRC-6 counter wrap
// - Word2 bit5: out-of-frame counter wrap
// - Word2 bit4: alignment change counter wrap
// - Word2 bit3: bipolar violation counter wrap
// - Word2 bit2: PRBS error counter wrap
// - Word2 bit1: PRBS multiframe counter wrap
// - Word2 bit0: multiframes-out-of-sync counter wrap
module tim_mask_logic (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [4:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata_q,
  input  wire tim_pkg::tim_level_t       cond_in,
  input  wire tim_pkg::tim_strobe_t      strobe_in,
  output logic      [tim_pkg::NUM_SRC-1:0] irq_event_q,
  output logic                           irq_req_q,
  output logic      [7:0]                irq_vector_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by write and read paths
  function automatic logic [1:0] decode_word(input logic [4:0] addr);
    logic [1:0] sel;
    sel = 2'h3;
    if (addr == tim_pkg::ADDR_MASK_SYNC_ALARM_SLIP)
      sel = 2'h0;
    else if (addr == tim_pkg::ADDR_MASK_LINE_ERRORS)
      sel = 2'h1;
    else if (addr == tim_pkg::ADDR_MASK_COUNTER_OVERFLOW)
      sel = 2'h2;
    return sel;
  endfunction : decode_word

  logic [7:0]                 irq_mask_sync_alarm_slip_q;
  logic [7:0]                 irq_mask_line_errors_q;
  logic [7:0]                 irq_mask_counter_overflow_q;
  logic [tim_pkg::NUM_SRC-1:0] mask_vec;
  logic [tim_pkg::NUM_SRC-1:0] raw_vec;
  tim_pkg::tim_level_t        cond_prev_q;
  logic                       primed_q;
  logic [3:0]                 cond_change;
  logic [1:0]                 wsel;
  logic [1:0]                 rsel;

  assign wsel = decode_word(reg_addr);
  assign rsel = decode_word(reg_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers; unused bits are never stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_mask_sync_alarm_slip_q  <= tim_pkg::RST_MASK;
      irq_mask_line_errors_q      <= tim_pkg::RST_MASK;
      irq_mask_counter_overflow_q <= tim_pkg::RST_MASK;
    end
    else if (reg_wr)
    begin
      if (wsel == 2'h0)
        irq_mask_sync_alarm_slip_q <= reg_wdata & tim_pkg::WR_MASK_SYNC_ALARM_SLIP;
      else if (wsel == 2'h1)
        irq_mask_line_errors_q <= reg_wdata & tim_pkg::WR_MASK_LINE_ERRORS;
      else if (wsel == 2'h2)
        irq_mask_counter_overflow_q <= reg_wdata & tim_pkg::WR_MASK_COUNTER_OVERFLOW;
    end
  end

  // Read data is registered; unmapped offsets answer zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata_q <= tim_pkg::READ_NONE;
    else if (reg_rd)
    begin
      if (rsel == 2'h0)
        reg_rdata_q <= irq_mask_sync_alarm_slip_q;
      else if (rsel == 2'h1)
        reg_rdata_q <= irq_mask_line_errors_q;
      else if (rsel == 2'h2)
        reg_rdata_q <= irq_mask_counter_overflow_q;
      else
        reg_rdata_q <= tim_pkg::READ_NONE;
    end
  end

  assign mask_vec = {irq_mask_counter_overflow_q, irq_mask_line_errors_q,
                     irq_mask_sync_alarm_slip_q};

  ////////////////////////////////////////////////////////////////////////////
  // Condition change detection. The first cycle after reset only primes the
  // history, so a condition already present at reset is not a change.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cond_prev_q <= '0;
      primed_q    <= 1'b0;
    end
    else
    begin
      cond_prev_q <= cond_in;
      primed_q    <= 1'b1;
    end
  end

  assign cond_change = primed_q ? (cond_in ^ cond_prev_q) : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Raw event vector in mask layout
  always_comb
  begin
    raw_vec                         = '0;
    raw_vec[tim_pkg::B_TFSYNC]      = cond_change[3];
    raw_vec[tim_pkg::B_MFSYNC]      = cond_change[2];
    raw_vec[tim_pkg::B_AIS]         = cond_change[1];
    raw_vec[tim_pkg::B_LOS]         = cond_change[0];
    raw_vec[tim_pkg::B_SEF]         = strobe_in.severe_frame_err;
    raw_vec[tim_pkg::B_TXSLIP]      = strobe_in.tx_buffer_slip;
    raw_vec[tim_pkg::B_RXSLIP]      = strobe_in.rx_buffer_slip;
    // Errors while out of sync are hunting noise, not line errors
    raw_vec[tim_pkg::B_FBE]         = strobe_in.framing_bit_err
                                      & cond_in.term_frame_sync;
    raw_vec[tim_pkg::B_CRC]         = strobe_in.crc6_err;
    raw_vec[tim_pkg::B_YEL]         = strobe_in.remote_alarm;
    raw_vec[tim_pkg::B_ALIGN]       = strobe_in.align_change;
    // Source already drops violations that form a valid B8ZS code
    raw_vec[tim_pkg::B_BPV]         = strobe_in.bipolar_violation;
    raw_vec[tim_pkg::B_PRBS]        = strobe_in.prbs_err;
    raw_vec[tim_pkg::B_PDV]         = strobe_in.pulse_density_err;
    raw_vec[tim_pkg::B_FBE_WRAP]    = strobe_in.framing_err_cnt_wrap;
    raw_vec[tim_pkg::B_CRC_WRAP]    = strobe_in.crc6_cnt_wrap;
    raw_vec[tim_pkg::B_OOF_WRAP]    = strobe_in.out_of_frame_cnt_wrap;
    raw_vec[tim_pkg::B_ALIGN_WRAP]  = strobe_in.align_change_cnt_wrap;
    raw_vec[tim_pkg::B_BPV_WRAP]    = strobe_in.bipolar_cnt_wrap;
    raw_vec[tim_pkg::B_PRBS_WRAP]   = strobe_in.prbs_err_cnt_wrap;
    raw_vec[tim_pkg::B_PRBSMF_WRAP] = strobe_in.prbs_multiframe_cnt_wrap;
    raw_vec[tim_pkg::B_MFOOS_WRAP]  = strobe_in.multiframe_unsync_cnt_wrap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source gating, one flop each
  genvar gi;
  generate
    for (gi = 0; gi < tim_pkg::NUM_SRC; gi++)
    begin : g_gate
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          irq_event_q[gi] <= 1'b0;
        else
          irq_event_q[gi] <= raw_vec[gi] & mask_vec[gi];
      end
    end
  endgenerate

  // Combined request, aligned with the event flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_req_q <= 1'b0;
    else
      irq_req_q <= |(raw_vec & mask_vec);
  end

  // Signal loss carries its own vector code alongside the request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_vector_q <= tim_pkg::NO_VECTOR;
    else if (raw_vec[tim_pkg::B_LOS] & mask_vec[tim_pkg::B_LOS])
      irq_vector_q <= tim_pkg::LOS_VECTOR;
    else
      irq_vector_q <= tim_pkg::NO_VECTOR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_masked_blocks;
    @(posedge clk) disable iff (!rst_n)
    (mask_vec == '0) |=> (irq_req_q == 1'b0);
  endproperty
  a_masked_blocks: assert property (p_masked_blocks)
    else $error("Interrupt raised with all masks clear");

  property p_tfsync_change;
    @(posedge clk) disable iff (!rst_n)
    (primed_q && irq_mask_sync_alarm_slip_q[tim_pkg::B_TFSYNC]
     && $changed(cond_in.term_frame_sync))
      |=> (irq_event_q[tim_pkg::B_TFSYNC] && irq_req_q);
  endproperty
  a_tfsync_change: assert property (p_tfsync_change)
    else $error("Frame sync change did not interrupt");

  property p_mfsync_change;
    @(posedge clk) disable iff (!rst_n)
    (primed_q && irq_mask_sync_alarm_slip_q[tim_pkg::B_MFSYNC]
     && $changed(cond_in.multiframe_sync)) |=> irq_event_q[tim_pkg::B_MFSYNC];
  endproperty
  a_mfsync_change: assert property (p_mfsync_change)
    else $error("Multiframe sync change did not interrupt");

  property p_ais_steady;
    @(posedge clk) disable iff (!rst_n)
    $stable(cond_in.all_ones_alarm) |=> !irq_event_q[tim_pkg::B_AIS];
  endproperty
  a_ais_steady: assert property (p_ais_steady)
    else $error("All-ones interrupt without a change");

  property p_los_vector;
    @(posedge clk) disable iff (!rst_n)
    irq_event_q[tim_pkg::B_LOS] |-> (irq_vector_q == tim_pkg::LOS_VECTOR);
  endproperty
  a_los_vector: assert property (p_los_vector)
    else $error("Signal loss interrupt without its vector");

  property p_slip_pair;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.tx_buffer_slip && irq_mask_sync_alarm_slip_q[tim_pkg::B_TXSLIP])
      ##1 !strobe_in.tx_buffer_slip
      |-> irq_event_q[tim_pkg::B_TXSLIP] ##1 !irq_event_q[tim_pkg::B_TXSLIP];
  endproperty
  a_slip_pair: assert property (p_slip_pair)
    else $error("Transmit slip interrupt not a single pulse");

  property p_rx_slip;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.rx_buffer_slip && irq_mask_sync_alarm_slip_q[tim_pkg::B_RXSLIP])
      |=> irq_event_q[tim_pkg::B_RXSLIP];
  endproperty
  a_rx_slip: assert property (p_rx_slip)
    else $error("Receive slip did not interrupt");

  property p_fbe_out_of_sync;
    @(posedge clk) disable iff (!rst_n)
    !cond_in.term_frame_sync |=> !irq_event_q[tim_pkg::B_FBE];
  endproperty
  a_fbe_out_of_sync: assert property (p_fbe_out_of_sync)
    else $error("Framing bit error interrupt while out of sync");

  property p_bpv_wrap;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.bipolar_cnt_wrap && mask_vec[tim_pkg::B_BPV_WRAP])
      |=> (irq_event_q[tim_pkg::B_BPV_WRAP] && irq_req_q);
  endproperty
  a_bpv_wrap: assert property (p_bpv_wrap)
    else $error("Bipolar counter wrap did not interrupt");

  property p_unused_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == tim_pkg::ADDR_MASK_SYNC_ALARM_SLIP)
      |=> (reg_rdata_q[tim_pkg::B_UNUSED0] == 1'b0);
  endproperty
  a_unused_read: assert property (p_unused_read)
    else $error("Unused mask bit read back as one");

  property p_unused_never;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (!irq_event_q[tim_pkg::B_UNUSED0] && !irq_event_q[tim_pkg::B_UNUSED1]);
  endproperty
  a_unused_never: assert property (p_unused_never)
    else $error("Unused position raised an event");

  // Any source, not only the ones probed by name
  property p_blocked_silent;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((irq_event_q & ~$past(mask_vec)) == '0);
  endproperty
  a_blocked_silent: assert property (p_blocked_silent)
    else $error("Event raised through a cleared mask bit");

  property p_sef_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.severe_frame_err && mask_vec[tim_pkg::B_SEF])
      |=> irq_event_q[tim_pkg::B_SEF];
  endproperty
  a_sef_event: assert property (p_sef_event)
    else $error("Severely errored frame did not interrupt");

  property p_crc_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.crc6_err && mask_vec[tim_pkg::B_CRC])
      |=> irq_event_q[tim_pkg::B_CRC];
  endproperty
  a_crc_event: assert property (p_crc_event)
    else $error("CRC-6 error did not interrupt");

  property p_remote_alarm;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.remote_alarm && mask_vec[tim_pkg::B_YEL])
      |=> irq_event_q[tim_pkg::B_YEL];
  endproperty
  a_remote_alarm: assert property (p_remote_alarm)
    else $error("Yellow alarm did not interrupt");

  property p_align_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.align_change && mask_vec[tim_pkg::B_ALIGN])
      |=> irq_event_q[tim_pkg::B_ALIGN];
  endproperty
  a_align_event: assert property (p_align_event)
    else $error("Alignment change did not interrupt");

  property p_bpv_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.bipolar_violation && mask_vec[tim_pkg::B_BPV])
      |=> irq_event_q[tim_pkg::B_BPV];
  endproperty
  a_bpv_event: assert property (p_bpv_event)
    else $error("Bipolar violation did not interrupt");

  property p_prbs_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.prbs_err && mask_vec[tim_pkg::B_PRBS])
      |=> irq_event_q[tim_pkg::B_PRBS];
  endproperty
  a_prbs_event: assert property (p_prbs_event)
    else $error("PRBS error did not interrupt");

  property p_pdv_event;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.pulse_density_err && mask_vec[tim_pkg::B_PDV])
      |=> irq_event_q[tim_pkg::B_PDV];
  endproperty
  a_pdv_event: assert property (p_pdv_event)
    else $error("Pulse density violation did not interrupt");

  property p_fbe_wrap;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.framing_err_cnt_wrap && mask_vec[tim_pkg::B_FBE_WRAP])
      |=> irq_event_q[tim_pkg::B_FBE_WRAP];
  endproperty
  a_fbe_wrap: assert property (p_fbe_wrap)
    else $error("Framing error counter wrap did not interrupt");

  property p_crc_wrap;
    @(posedge clk) disable iff (!rst_n)
    (strobe_in.crc6_cnt_wrap && mask_vec[tim_pkg::B_CRC_WRAP])
      |=> irq_event_q[tim_pkg::B_CRC_WRAP];
  endproperty
  a_crc_wrap: assert property (p_crc_wrap)
    else $error("CRC-6 counter wrap did not interrupt");

endmodule : tim_mask_logic

//--- logic/tim_pkg.sv
package tim_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets within the page (A4..A0)
  localparam logic [4:0] ADDR_MASK_SYNC_ALARM_SLIP  = 5'h1B;
  localparam logic [4:0] ADDR_MASK_LINE_ERRORS      = 5'h1C;
  localparam logic [4:0] ADDR_MASK_COUNTER_OVERFLOW = 5'h1D;

  // Reset values, all sources blocked
  localparam logic [7:0] RST_MASK = 8'h00;

  // Writable bits; unused positions stay zero
  localparam logic [7:0] WR_MASK_SYNC_ALARM_SLIP  = 8'hDF;
  localparam logic [7:0] WR_MASK_LINE_ERRORS      = 8'hFE;
  localparam logic [7:0] WR_MASK_COUNTER_OVERFLOW = 8'hFF;

  localparam logic [7:0] READ_NONE  = 8'h00;
  localparam logic [7:0] LOS_VECTOR = 8'h40;
  localparam logic [7:0] NO_VECTOR  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions in the 24-bit event vector {word two, word one, word zero}
  localparam int NUM_SRC        = 24;
  localparam int B_TFSYNC       = 7;
  localparam int B_MFSYNC       = 6;
  localparam int B_AIS          = 4;
  localparam int B_LOS          = 3;
  localparam int B_SEF          = 2;
  localparam int B_TXSLIP       = 1;
  localparam int B_RXSLIP       = 0;
  localparam int B_FBE          = 15;
  localparam int B_CRC          = 14;
  localparam int B_YEL          = 13;
  localparam int B_ALIGN        = 12;
  localparam int B_BPV          = 11;
  localparam int B_PRBS         = 10;
  localparam int B_PDV          = 9;
  localparam int B_UNUSED1      = 8;
  localparam int B_UNUSED0      = 5;
  localparam int B_FBE_WRAP     = 23;
  localparam int B_CRC_WRAP     = 22;
  localparam int B_OOF_WRAP     = 21;
  localparam int B_ALIGN_WRAP   = 20;
  localparam int B_BPV_WRAP     = 19;
  localparam int B_PRBS_WRAP    = 18;
  localparam int B_PRBSMF_WRAP  = 17;
  localparam int B_MFOOS_WRAP   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Condition levels from the framer and alarm blocks
  typedef struct packed {
    logic term_frame_sync;
    logic multiframe_sync;
    logic all_ones_alarm;
    logic signal_loss;
  } tim_level_t;

  // One-cycle strobes from the framer, alarm and counter blocks
  typedef struct packed {
    logic severe_frame_err;
    logic tx_buffer_slip;
    logic rx_buffer_slip;
    logic framing_bit_err;
    logic crc6_err;
    logic remote_alarm;
    logic align_change;
    logic bipolar_violation;
    logic prbs_err;
    logic pulse_density_err;
    logic framing_err_cnt_wrap;
    logic crc6_cnt_wrap;
    logic out_of_frame_cnt_wrap;
    logic align_change_cnt_wrap;
    logic bipolar_cnt_wrap;
    logic prbs_err_cnt_wrap;
    logic prbs_multiframe_cnt_wrap;
    logic multiframe_unsync_cnt_wrap;
  } tim_strobe_t;

endpackage : tim_pkg

//--- verif/tim_event_src.sv
////////////////////////////////////////////////////////////////////////////////
// Framer, alarm and counter event sources seen by the mask logic
module tim_event_src (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ev_req,
  input  wire logic [4:0]            ev_sel,
  output tim_pkg::tim_level_t        cond_q,
  output tim_pkg::tim_strobe_t       strobe_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes last one cycle only, as the real sub-blocks give them
  always_ff @(posedge clk)
  begin
    strobe_q <= '0;
    if (!rst_n)
    begin
      cond_q <= '0;
    end
    else if (ev_req && ev_sel < 5'h12)
    begin
      strobe_q[5'h11 - ev_sel] <= 1'b1;
    end
    else if (ev_req)
    begin
      // Levels flip, so each request is one change of state
      cond_q[5'h15 - ev_sel] <= ~cond_q[5'h15 - ev_sel];
    end
  end
endmodule : tim_event_src

//--- verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  rst_n;
  logic [4:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [7:0]            reg_rdata;
  logic                  ev_req;
  logic [4:0]            ev_sel;
  tim_pkg::tim_level_t   cond;
  tim_pkg::tim_strobe_t  strobe;
  logic [23:0]           irq_event;
  logic                  irq_req;
  logic [7:0]            irq_vector;
  int                    miscompares;
  int                    checks_done;
  // Vector bit of each request code: 18 strobes, then 4 levels
  localparam int MAP [22] = '{2, 1, 0, 15, 14, 13, 12, 11, 10, 9, 23, 22, 21, 20, 19, 18,
                              17, 16, 7, 6, 4, 3};

  tim_mask_logic dut (
    .clk          (clk),
    .rst_n        (rst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata_q  (reg_rdata),
    .cond_in      (cond),
    .strobe_in    (strobe),
    .irq_event_q  (irq_event),
    .irq_req_q    (irq_req),
    .irq_vector_q (irq_vector)
  );

  tim_event_src src (
    .clk      (clk),
    .rst_n    (rst_n),
    .ev_req   (ev_req),
    .ev_sel   (ev_sel),
    .cond_q   (cond),
    .strobe_q (strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check("read data", {16'h0000, reg_rdata}, {16'h0000, exp});
  endtask : reg_read

  task automatic set_mask(input logic [23:0] m);
    reg_write(tim_pkg::ADDR_MASK_SYNC_ALARM_SLIP, m[7:0]);
    reg_write(tim_pkg::ADDR_MASK_LINE_ERRORS, m[15:8]);
    reg_write(tim_pkg::ADDR_MASK_COUNTER_OVERFLOW, m[23:16]);
  endtask : set_mask

  // Result shows one cycle after the source has moved
  task automatic fire(input int sel, input logic [23:0] exp);
    @(posedge clk);
    ev_sel <= 5'(sel);
    ev_req <= 1'b1;
    @(posedge clk);
    ev_req <= 1'b0;
    @(posedge clk);
    #1;
    check("event vector", irq_event, exp);
    check("request", {23'h000000, irq_req}, {23'h000000, exp != 24'h000000});
    check("vector", {16'h0000, irq_vector}, {16'h0000, exp[3] ? 8'h40 : 8'h00});
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog against a hung sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial
  begin
    rst_n       = 1'b0;
    reg_addr    = 5'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    ev_req      = 1'b0;
    ev_sel      = 5'h00;
    miscompares = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(tim_pkg::ADDR_MASK_SYNC_ALARM_SLIP, 8'h00);
    reg_read(tim_pkg::ADDR_MASK_LINE_ERRORS, 8'h00);
    reg_read(tim_pkg::ADDR_MASK_COUNTER_OVERFLOW, 8'h00);
    set_mask(24'hFFFFFF);
    reg_write(5'h1A, 8'hFF);
    reg_read(5'h1A, 8'h00);
    reg_read(tim_pkg::ADDR_MASK_SYNC_ALARM_SLIP, 8'hDF);
    reg_read(tim_pkg::ADDR_MASK_LINE_ERRORS, 8'hFE);
    reg_read(tim_pkg::ADDR_MASK_COUNTER_OVERFLOW, 8'hFF);
    // Out of terminal sync, a framing bit error stays quiet
    fire(3, 24'h000000);
    for (int s = 18; s < 22; s++)
      fire(s, 24'h000001 << MAP[s]);
    // Each source alone unmasked, then alone masked
    for (int s = 0; s < 22; s++)
    begin
      set_mask(24'h000001 << MAP[s]);
      fire(s, 24'h000001 << MAP[s]);
      set_mask(~(24'h000001 << MAP[s]));
      fire(s, 24'h000000);
    end
    close_out();
  end
endmodule : testbench
